/* File: hdl/pad_mux_pkg.sv */
// constants for the pad direction multiplexer and gpio block
package pad_mux_pkg;

  // register byte offsets
  localparam logic [11:0] VARIANT_CTRL_OFS      = 12'h000;
  localparam logic [11:0] PORT_INPUT_DATA_OFS   = 12'h004;
  localparam logic [11:0] PORT_OUTPUT_DATA_OFS  = 12'h008;
  localparam logic [11:0] PORT_SET_OUT_OFS      = 12'h00C;
  localparam logic [11:0] PORT_CLEAR_OUT_OFS    = 12'h010;
  localparam logic [11:0] PORT_TOGGLE_OUT_OFS   = 12'h014;
  localparam logic [11:0] GPIO_DATA_WORD_OFS    = 12'h018;
  localparam logic [11:0] GPIO_DIRECTION_OFS    = 12'h01C;
  localparam logic [11:0] PAD_SAMPLE_WORD_OFS   = 12'h020;
  localparam logic [11:0] PAD_CONFIG_BASE_OFS   = 12'h100;

  // pad_config_word fields
  localparam int INPUT_PATH_ENABLE_BIT  = 0;
  localparam int OUTPUT_PATH_ENABLE_BIT = 1;
  localparam int OPEN_DRAIN_ENABLE_BIT  = 10;
  localparam int INPUT_ON_OVERRIDE_BIT  = 30;
  localparam int ALT_FUNCTION_LSB       = 20;
  localparam int ALT_FUNCTION_MSB       = 22;
  localparam int ALT_FUNCTION_COUNT     = 8;

  // drive strength 001 and pull strength 10, every other field zero
  localparam logic [31:0] PAD_CONFIG_RESET = 32'h0000_0060;
  // writable: override, function select, bits 13..0
  localparam logic [31:0] PAD_CONFIG_WMASK = 32'h4070_3FFF;

  localparam logic [2:0] GPIO_FUNCTION    = 3'h0;
  localparam logic [2:0] TWO_WIRE_FUNCTION = 3'h1;

  typedef enum logic { VARIANT_EXPLICIT, VARIANT_FUNCTION } variant_t;

  // ahb-lite encodings
  localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
  localparam logic [1:0] HRESP_OKAY    = 2'h0;

endpackage

/* File: hdl/pad_direction_mux_gpio.sv */
// pad configuration, per-pin direction multiplexer and gpio data path
// Summary of operation
// - one 32-bit pad config word per pin
// - explicit variant: path enables set by software
// - input-only, output-only or bidirectional per pin
// - input enabled pins captured into port input
// - output enabled pins driven from port output
// - pin level readable while driven as output
// - set, clear, toggle registers modify output bits
// - gpio registers hold one bit per pin
// - direction word drives the path enables
// - direction 0: pin captured into gpio data
// - direction 1: pin driven from gpio data
// - output pins read back stored data value
// - override forces input path on
// - read-only pad sample register of pin levels
// - two-wire function enables output path automatically
// - combinational multiplexing cell per pin
//
// Added by the designer: the AHB-Lite register port and the address map.
`timescale 1ns/10ps

module pad_direction_mux_gpio
  import pad_mux_pkg::*;
#(
  parameter int NUM_PINS = 32
) (
  // clock and reset
  input  wire logic                                   CORE_CLK,
  input  wire logic                                   RST_N,
  // ahb-lite slave
  input  wire logic                                   HSEL,
  input  wire logic [11:0]                            HADDR,
  input  wire logic [1:0]                             HTRANS,
  input  wire logic                                   HWRITE,
  input  wire logic [2:0]                             HSIZE,
  input  wire logic                                   HREADY,
  input  wire logic [31:0]                            HWDATA,
  output logic      [31:0]                            HRDATA,
  output logic                                        HREADYOUT,
  output logic      [1:0]                             HRESP,
  // pads
  input  wire logic [NUM_PINS-1:0]                    PAD_IN,
  output logic      [NUM_PINS-1:0]                    PAD_OUT,
  output logic      [NUM_PINS-1:0]                    PAD_OE,
  // alternate-function peripherals, ALT_FUNCTION_COUNT slots per pin
  input  wire logic [NUM_PINS*ALT_FUNCTION_COUNT-1:0] ALT_DO,
  input  wire logic [NUM_PINS*ALT_FUNCTION_COUNT-1:0] ALT_DIR,
  output logic      [NUM_PINS*ALT_FUNCTION_COUNT-1:0] ALT_DI
);

  if (NUM_PINS < 1 || NUM_PINS > 32) begin : g_bad_pins
    $error("NUM_PINS must be 1 to 32");
  end

  variant_t            variant_r;
  logic [31:0]         pad_config_r [NUM_PINS];
  logic [NUM_PINS-1:0] port_input_data_r;
  logic [NUM_PINS-1:0] port_output_data_r;
  logic [NUM_PINS-1:0] gpio_data_word_r;
  logic [NUM_PINS-1:0] gpio_direction_word_r;
  logic [NUM_PINS-1:0] pad_sample_word_r;

  // per-pin cell results
  logic [NUM_PINS-1:0] path_oe;
  logic [NUM_PINS-1:0] path_ie;
  logic [NUM_PINS-1:0] drive_val;
  logic [NUM_PINS-1:0] pin_oe_nxt;
  logic [NUM_PINS-1:0] pin_out_nxt;
  logic [2:0]          alt_sel [NUM_PINS];

  // bus state
  logic                wr_pend_r;
  logic                rd_pend_r;
  logic [11:0]         addr_r;
  logic                take;
  logic [31:0]         rdata_nxt;
  logic                wr_en;

  assign take  = HSEL && HTRANS == HTRANS_NONSEQ && HREADY;
  assign wr_en = wr_pend_r;

  // combinational multiplexing cell, one per pin
  for (genvar i = 0; i < NUM_PINS; i++) begin : g_cell
    logic [2:0] sel;
    logic       open_drain_enable;
    logic       input_on_override;
    logic       per_do;
    logic       per_dir;
    assign sel     = pad_config_r[i][ALT_FUNCTION_MSB:ALT_FUNCTION_LSB];
    assign alt_sel[i] = sel;
    assign open_drain_enable     = pad_config_r[i][OPEN_DRAIN_ENABLE_BIT];
    assign input_on_override    = pad_config_r[i][INPUT_ON_OVERRIDE_BIT];
    assign per_do  = ALT_DO[i*ALT_FUNCTION_COUNT + int'(sel)];
    assign per_dir = ALT_DIR[i*ALT_FUNCTION_COUNT + int'(sel)];

    always_comb begin
      if (variant_r == VARIANT_EXPLICIT) begin
        // no automatic override of software direction
        path_oe[i] = pad_config_r[i][OUTPUT_PATH_ENABLE_BIT];
        path_ie[i] = pad_config_r[i][INPUT_PATH_ENABLE_BIT] | input_on_override;
        drive_val[i] = (sel == GPIO_FUNCTION) ? port_output_data_r[i] : per_do;
      end else if (sel == GPIO_FUNCTION) begin
        path_oe[i]   = gpio_direction_word_r[i];
        path_ie[i]   = ~gpio_direction_word_r[i] | input_on_override;
        drive_val[i] = gpio_data_word_r[i];
      end else begin
        // two-wire pins read back only through the override
        path_oe[i]   = per_dir | (sel == TWO_WIRE_FUNCTION);
        path_ie[i]   = (~per_dir & (sel != TWO_WIRE_FUNCTION)) | input_on_override;
        drive_val[i] = per_do;
      end
      // open drain drives only the low level
      pin_oe_nxt[i]  = path_oe[i] & (~open_drain_enable | ~drive_val[i]);
      pin_out_nxt[i] = drive_val[i] & ~open_drain_enable;
    end

    for (genvar k = 0; k < ALT_FUNCTION_COUNT; k++) begin : g_alt
      always_ff @(posedge CORE_CLK) begin
        if (!RST_N) begin
          ALT_DI[i*ALT_FUNCTION_COUNT + k] <= 1'b0;
        end else begin
          ALT_DI[i*ALT_FUNCTION_COUNT + k] <= (int'(sel) == k) & path_ie[i] & PAD_IN[i];
        end
      end
    end
  end

  // pad drivers, registered so the pins never glitch on config writes
  always_ff @(posedge CORE_CLK) begin
    if (!RST_N) begin
      PAD_OE  <= '0;
      PAD_OUT <= '0;
    end else begin
      PAD_OE  <= pin_oe_nxt;
      PAD_OUT <= pin_out_nxt;
    end
  end

  // input capture: pin level kept even while driven
  always_ff @(posedge CORE_CLK) begin
    if (!RST_N) begin
      port_input_data_r <= '0;
      pad_sample_word_r <= '0;
    end else begin
      port_input_data_r <= PAD_IN & path_ie;
      pad_sample_word_r <= PAD_IN & path_ie;
    end
  end

  // bus address phase capture; reads take one wait state
  always_ff @(posedge CORE_CLK) begin
    if (!RST_N) begin
      wr_pend_r <= 1'b0;
      rd_pend_r <= 1'b0;
      addr_r    <= '0;
      HREADYOUT <= 1'b1;
      HRESP     <= HRESP_OKAY;
    end else begin
      wr_pend_r <= take && HWRITE;
      rd_pend_r <= take && !HWRITE;
      HREADYOUT <= !(take && !HWRITE);
      HRESP     <= HRESP_OKAY;
      if (take) begin
        addr_r <= {HADDR[11:2], 2'b00};
      end
    end
  end

  // read mux; unmapped offsets read zero
  always_comb begin
    rdata_nxt = 32'h0000_0000;
    unique case (addr_r)
      VARIANT_CTRL_OFS:     rdata_nxt[0] = variant_r;
      PORT_INPUT_DATA_OFS:  rdata_nxt[NUM_PINS-1:0] = port_input_data_r;
      PORT_OUTPUT_DATA_OFS: rdata_nxt[NUM_PINS-1:0] = port_output_data_r;
      GPIO_DATA_WORD_OFS:   rdata_nxt[NUM_PINS-1:0] = gpio_data_word_r;
      GPIO_DIRECTION_OFS:   rdata_nxt[NUM_PINS-1:0] = gpio_direction_word_r;
      PAD_SAMPLE_WORD_OFS:  rdata_nxt[NUM_PINS-1:0] = pad_sample_word_r;
      default: begin
        for (int p = 0; p < NUM_PINS; p++) begin
          if (addr_r == PAD_CONFIG_BASE_OFS + 12'(p * 4)) begin
            // path enable bits show the effective direction
            rdata_nxt = {pad_config_r[p][31:2], path_oe[p], path_ie[p]};
          end
        end
      end
    endcase
  end

  always_ff @(posedge CORE_CLK) begin
    if (!RST_N) begin
      HRDATA <= '0;
    end else if (rd_pend_r) begin
      HRDATA <= rdata_nxt;
    end
  end

  always_ff @(posedge CORE_CLK) begin
    if (!RST_N) begin
      variant_r <= VARIANT_EXPLICIT;
    end else if (wr_en && addr_r == VARIANT_CTRL_OFS) begin
      variant_r <= variant_t'(HWDATA[0]);
    end
  end

  // pad config words
  always_ff @(posedge CORE_CLK) begin
    if (!RST_N) begin
      for (int p = 0; p < NUM_PINS; p++) begin
        pad_config_r[p] <= PAD_CONFIG_RESET;
      end
    end else if (wr_en) begin
      for (int p = 0; p < NUM_PINS; p++) begin
        if (addr_r == PAD_CONFIG_BASE_OFS + 12'(p * 4)) begin
          pad_config_r[p] <= HWDATA & PAD_CONFIG_WMASK;
        end
      end
    end
  end

  // port output data with set, clear, toggle side effects
  always_ff @(posedge CORE_CLK) begin
    if (!RST_N) begin
      port_output_data_r <= '0;
    end else if (wr_en) begin
      unique case (addr_r)
        PORT_OUTPUT_DATA_OFS: port_output_data_r <= HWDATA[NUM_PINS-1:0];
        PORT_SET_OUT_OFS:     port_output_data_r <= port_output_data_r | HWDATA[NUM_PINS-1:0];
        PORT_CLEAR_OUT_OFS:   port_output_data_r <= port_output_data_r & ~HWDATA[NUM_PINS-1:0];
        PORT_TOGGLE_OUT_OFS:  port_output_data_r <= port_output_data_r ^ HWDATA[NUM_PINS-1:0];
        default:              port_output_data_r <= port_output_data_r;
      endcase
    end
  end

  // gpio direction word, one bit per pin
  always_ff @(posedge CORE_CLK) begin
    if (!RST_N) begin
      gpio_direction_word_r <= '0;
    end else if (wr_en && addr_r == GPIO_DIRECTION_OFS) begin
      gpio_direction_word_r <= HWDATA[NUM_PINS-1:0];
    end
  end

  // input bits follow the pin, output bits keep the written value
  always_ff @(posedge CORE_CLK) begin
    if (!RST_N) begin
      gpio_data_word_r <= '0;
    end else begin
      for (int p = 0; p < NUM_PINS; p++) begin
        if (!gpio_direction_word_r[p]) begin
          gpio_data_word_r[p] <= PAD_IN[p];
        end else if (wr_en && addr_r == GPIO_DATA_WORD_OFS) begin
          gpio_data_word_r[p] <= HWDATA[p];
        end
      end
    end
  end

  // checks on pin 0; the set, toggle and sample_ro_a checks cover every pin
  cfg_reset_a: assert property (@(posedge CORE_CLK)
    !RST_N |=> pad_config_r[0] == PAD_CONFIG_RESET && !PAD_OE[0])
    else $error("pad config not at reset value");

  explicit_dir_a: assert property (@(posedge CORE_CLK) disable iff (!RST_N)
    variant_r == VARIANT_EXPLICIT |->
      path_oe[0] == pad_config_r[0][OUTPUT_PATH_ENABLE_BIT] &&
      path_ie[0] == (pad_config_r[0][INPUT_PATH_ENABLE_BIT] |
                     pad_config_r[0][INPUT_ON_OVERRIDE_BIT]))
    else $error("explicit direction overridden");

  out_drive_a: assert property (@(posedge CORE_CLK) disable iff (!RST_N)
    variant_r == VARIANT_EXPLICIT && alt_sel[0] == GPIO_FUNCTION && path_oe[0] &&
    !pad_config_r[0][OPEN_DRAIN_ENABLE_BIT]
      |=> PAD_OE[0] && PAD_OUT[0] == $past(port_output_data_r[0]))
    else $error("pin not driven from port output");

  input_cap_a: assert property (@(posedge CORE_CLK) disable iff (!RST_N)
    path_ie[0] |=> port_input_data_r[0] == $past(PAD_IN[0]))
    else $error("pin level not captured");

  set_out_a: assert property (@(posedge CORE_CLK) disable iff (!RST_N)
    wr_en && addr_r == PORT_SET_OUT_OFS
      |=> port_output_data_r == ($past(port_output_data_r) | $past(HWDATA[NUM_PINS-1:0])))
    else $error("set register wrong");

  toggle_out_a: assert property (@(posedge CORE_CLK) disable iff (!RST_N)
    wr_en && addr_r == PORT_TOGGLE_OUT_OFS
      |=> port_output_data_r == ($past(port_output_data_r) ^ $past(HWDATA[NUM_PINS-1:0])))
    else $error("toggle register wrong");

  dir_in_a: assert property (@(posedge CORE_CLK) disable iff (!RST_N)
    !gpio_direction_word_r[0] |=> gpio_data_word_r[0] == $past(PAD_IN[0]))
    else $error("input pin not captured into gpio data");

  dir_out_a: assert property (@(posedge CORE_CLK) disable iff (!RST_N)
    variant_r == VARIANT_FUNCTION && alt_sel[0] == GPIO_FUNCTION &&
    gpio_direction_word_r[0] && !pad_config_r[0][OPEN_DRAIN_ENABLE_BIT]
      |=> PAD_OE[0] && PAD_OUT[0] == $past(gpio_data_word_r[0]))
    else $error("output pin not driven from gpio data");

  override_a: assert property (@(posedge CORE_CLK) disable iff (!RST_N)
    pad_config_r[0][INPUT_ON_OVERRIDE_BIT] ##1 pad_config_r[0][INPUT_ON_OVERRIDE_BIT]
      |-> pad_sample_word_r[0] == $past(PAD_IN[0]))
    else $error("override did not sample pin");

  two_wire_a: assert property (@(posedge CORE_CLK) disable iff (!RST_N)
    variant_r == VARIANT_FUNCTION && alt_sel[0] == TWO_WIRE_FUNCTION |-> path_oe[0])
    else $error("two-wire function output path off");

  sample_ro_a: assert property (@(posedge CORE_CLK) disable iff (!RST_N)
    wr_en && addr_r == PAD_SAMPLE_WORD_OFS |=> pad_sample_word_r == $past(PAD_IN & path_ie))
    else $error("pad sample register written");

  bidir_c: cover property (@(posedge CORE_CLK) disable iff (!RST_N)
    path_oe[0] && path_ie[0] ##1 PAD_OE[0]);
  func_out_c: cover property (@(posedge CORE_CLK) disable iff (!RST_N)
    variant_r == VARIANT_FUNCTION && gpio_direction_word_r[0] ##1 PAD_OE[0]);
  read_c: cover property (@(posedge CORE_CLK) disable iff (!RST_N)
    rd_pend_r ##1 HREADYOUT);

endmodule

/* File: dv/pad_world.sv */
// far side of the pads: external drivers and pull-ups on every pin
`timescale 1ns/10ps

module pad_world #(
  parameter int N = 32
) (
  // design side
  input  wire logic [N-1:0] pad_out,
  input  wire logic [N-1:0] pad_oe,
  // outside drivers, commanded by the bench
  input  wire logic [N-1:0] ext_en,
  input  wire logic [N-1:0] ext_val,
  // level seen by the design
  output logic      [N-1:0] pad_in
);
  // released lines float to the pull-up level; low wins a clash
  assign pad_in = (~pad_oe | pad_out) & (~ext_en | ext_val);
endmodule

/* File: dv/pad_direction_mux_gpio_tb_top.sv */
// self-checking bench for the pad multiplexer and gpio block
`timescale 1ns/10ps

module pad_direction_mux_gpio_tb_top;
  import pad_mux_pkg::*;
  localparam int NP = 32;
  // pin 6 is the explicit-variant open-drain pin
  localparam logic [31:0] OD_PIN  = 32'h0000_0040;
  // open drain, keeper/pull on, pull selected, strength 11
  localparam logic [31:0] OD_PULL = 32'h0000_041C;
  logic         clk       = 1'b0;
  logic         rst_n     = 1'b0;
  logic         hsel      = 1'b0;
  logic         hwrite    = 1'b0;
  logic [11:0]  haddr     = '0;
  logic [1:0]   htrans    = '0;
  logic [31:0]  hwdata    = '0;
  logic [31:0]  ext_en    = '0;
  logic [31:0]  ext_val   = '0;
  logic [255:0] alt_do    = '0;
  logic [255:0] alt_dir   = '0;
  logic [1:0]   hresp;
  logic         hreadyout;
  logic [31:0]  hrdata, pad_in, pad_out, pad_oe, rd, dir, dat, ibm, obm, exp;
  logic [255:0] alt_di;
  int           err_count = 0;
  int           checks    = 0;

  always #50 clk = ~clk;

  pad_direction_mux_gpio #(.NUM_PINS(NP)) i_dut (
    .CORE_CLK(clk), .RST_N(rst_n), .HSEL(hsel), .HADDR(haddr), .HTRANS(htrans),
    .HWRITE(hwrite), .HSIZE(3'h2), .HREADY(hreadyout), .HWDATA(hwdata),
    .HRDATA(hrdata), .HREADYOUT(hreadyout), .HRESP(hresp), .PAD_IN(pad_in),
    .PAD_OUT(pad_out), .PAD_OE(pad_oe), .ALT_DO(alt_do), .ALT_DIR(alt_dir),
    .ALT_DI(alt_di));

  pad_world #(.N(NP)) i_world (.pad_out(pad_out), .pad_oe(pad_oe), .ext_en(ext_en),
    .ext_val(ext_val), .pad_in(pad_in));

  task automatic tally_and_finish;
    if (err_count == 0 && checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] want);
    checks++;
    if (got !== want) begin
      err_count++;
      $display("[FAIL] %0t ns: got %h, expected %h", $time, got, want);
    end
  endtask

  // one single transfer; entered just after a rising edge
  task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d);
    hsel <= 1'b1;
    htrans <= HTRANS_NONSEQ;
    haddr <= a;
    hwrite <= w;
    do @(posedge clk); while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge clk); while (hreadyout !== 1'b1);
    rd = hrdata;
  endtask

  task automatic rdc(input logic [11:0] a, input logic [31:0] want);
    xfer(1'b0, a, '0);
    chk(rd, want);
  endtask

  task automatic settle;
    // alt inputs need a second edge: pad driver, then capture; the third edge is spare
    repeat (3) @(posedge clk);
  endtask

  function automatic logic [11:0] cfg(input int p);
    return PAD_CONFIG_BASE_OFS + 12'(4 * p);
  endfunction

  function automatic logic [31:0] lvl(input logic [31:0] oe, input logic [31:0] o);
    return (~oe | o) & (~ext_en | ext_val);
  endfunction

  function automatic logic [31:0] op(input int k, input logic [31:0] c, input logic [31:0] m);
    if (k == 0) return c | m;
    if (k == 1) return c & ~m;
    return c ^ m;
  endfunction

  initial begin
    repeat (5000) @(posedge clk);
    err_count++;
    tally_and_finish;
  end

  initial begin
    void'($urandom(6807));
    repeat (12) @(posedge clk);
    rst_n <= 1'b1;
    alt_do <= {8{$urandom()}};
    alt_dir <= {8{$urandom()}};
    @(posedge clk);
    chk(pad_oe, '0);
    rdc(cfg(0), PAD_CONFIG_RESET);
    rdc(cfg(31), PAD_CONFIG_RESET);
    // explicit variant; pins 0..3 cover both, in only, out only, none
    ibm = $urandom();
    obm = $urandom();
    ibm[3:0] = 4'b0011;
    obm[3:0] = 4'b0101;
    ibm[6] = 1'b1;
    obm[6] = 1'b1;
    for (int p = 0; p < NP; p++) begin
      exp = PAD_CONFIG_RESET | {30'h0, obm[p], ibm[p]};
      if (p == 6) exp = exp | OD_PULL;
      xfer(1'b1, cfg(p), exp);
    end
    dat = $urandom();
    ext_en <= ~obm;
    ext_val <= $urandom();
    xfer(1'b1, PORT_OUTPUT_DATA_OFS, dat);
    settle;
    chk(pad_oe, obm & ~(OD_PIN & dat));
    chk(pad_out & obm, dat & obm & ~OD_PIN);
    rdc(PORT_INPUT_DATA_OFS, ibm & lvl(obm, dat));
    rdc(cfg(2), PAD_CONFIG_RESET | 32'h2);
    for (int k = 0; k < 3; k++) begin
      exp = $urandom();
      dat = op(k, dat, exp);
      xfer(1'b1, PORT_SET_OUT_OFS + 12'(4 * k), exp);
      settle;
      chk(pad_out & obm, dat & obm & ~OD_PIN);
      rdc(PORT_OUTPUT_DATA_OFS, dat);
    end
    rdc(PORT_TOGGLE_OUT_OFS, '0);
    xfer(1'b1, 12'h0FC, 32'hFFFF_FFFF);
    rdc(12'h0FC, '0);
    // function-driven variant, gpio function everywhere
    for (int p = 0; p < NP; p++) xfer(1'b1, cfg(p), PAD_CONFIG_RESET);
    xfer(1'b1, VARIANT_CTRL_OFS, 32'h1);
    dir = $urandom();
    dir[0] = 1'b1;
    dir[3] = 1'b1;
    dir[4] = 1'b0;
    dat = $urandom();
    ext_en <= ~dir;
    xfer(1'b1, GPIO_DIRECTION_OFS, dir);
    xfer(1'b1, GPIO_DATA_WORD_OFS, dat);
    settle;
    chk(pad_oe, dir);
    chk(pad_out & dir, dat & dir);
    exp = (dat & dir) | (lvl(dir, dat) & ~dir);
    rdc(GPIO_DATA_WORD_OFS, exp);
    rdc(PAD_SAMPLE_WORD_OFS, lvl(dir, dat) & ~dir);
    xfer(1'b1, cfg(3), PAD_CONFIG_RESET | 32'h4000_0000);
    xfer(1'b1, cfg(0), PAD_CONFIG_RESET | 32'h4000_0000);
    xfer(1'b1, PAD_SAMPLE_WORD_OFS, $urandom());
    settle;
    rdc(PAD_SAMPLE_WORD_OFS, lvl(dir, dat) & (~dir | 32'h9));
    rdc(GPIO_DATA_WORD_OFS, exp);
    // two-wire bus on pins 4 and 0: open drain, override, strong pull-up
    xfer(1'b1, cfg(4), 32'h4010_047C);
    xfer(1'b1, cfg(0), 32'h4010_047C);
    for (int v = 0; v < 4; v++) begin
      alt_do[33] <= v[0];
      alt_do[1] <= v[0];
      ext_en[4] <= v[1];
      ext_en[0] <= v[1];
      ext_val[4] <= 1'b0;
      ext_val[0] <= 1'b0;
      settle;
      chk({pad_oe[4], pad_out[4], pad_oe[0], pad_out[0]}, {2{~v[0], 1'b0}});
      chk({alt_di[32 +: 8], alt_di[0 +: 8]}, {2{6'h0, v[0] & ~v[1], 1'b0}});
    end
    // every other function on pin 5, half output, half input
    for (int f = 2; f < 8; f++) begin
      alt_dir[40 + f] <= f[0];
      alt_do[40 + f] <= f[1];
      ext_en[5] <= ~f[0];
      ext_val[5] <= f[2];
      xfer(1'b1, cfg(5), PAD_CONFIG_RESET | (32'(f) << 20));
      settle;
      chk({pad_oe[5], pad_oe[5] & pad_out[5]}, {f[0], f[0] & f[1]});
      chk(alt_di[40 +: 8], 8'(~f[0] & f[2]) << f);
    end
    chk(pad_oe & ~32'h31, dir & ~32'h31);
    chk({30'h0, hresp}, {30'h0, HRESP_OKAY});
    tally_and_finish;
  end
endmodule
